// File: dtc_pkg.sv
// How it works
// (R1) Each count is 16 bits, two byte registers
// (R2) Modes: 13-bit, 16-bit, 8-bit reload, split
// (R3) Each timer has its own mode fields
// (R4) Five timebases: select bit plus prescale code
// (R5) Select bit picks system or prescaled clock
// (R6) Code 00 is sys/12, 11 is osc/8
// (R7) Counter mode counts falling pin edges
// (R8) Events up to quarter system clock counted
// (R9) Pin levels must stay two clocks
// (R10) Control register holds runs and flags
// (R11) Interrupt request passes only when enabled
// (R12) 13-bit: high byte plus low five bits
// (R13) Software masks low byte bits 7..5
// (R14) 13-bit wrap sets overflow flag bit 5
// (R15) Timer B mirrors timer A behaviour; B holds in split mode, counts its timebase without run while A is split
// (R16) Counter-select bit picks pin edge counting
// (R17) Timer A select bit 3 picks clock
// (R18) Count needs run and gate or input
// (R19) Setting run never clears the count
// (R20) Pin synchronised by two flops first
// (R21) Timer B overflow strobe for baud ticks
package dtc_pkg;
    localparam int ADDR_W = 4;
    typedef logic [ADDR_W-1:0] dtc_addr_t;
    typedef logic [7:0]        dtc_byte_t;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam dtc_addr_t OFF_CTRL  = 4'h0;
    localparam dtc_addr_t OFF_MODE  = 4'h1;
    localparam dtc_addr_t OFF_CLK   = 4'h2;
    localparam dtc_addr_t OFF_IEN   = 4'h3;
    localparam dtc_addr_t OFF_LO_A  = 4'h4;
    localparam dtc_addr_t OFF_LO_B  = 4'h5;
    localparam dtc_addr_t OFF_HI_A  = 4'h6;
    localparam dtc_addr_t OFF_HI_B  = 4'h7;
    localparam dtc_byte_t RST_BYTE  = 8'h00;
    // ------------------------------------------------------------
    // Field positions (timer B fields sit one stride above A)
    // ------------------------------------------------------------
    localparam int CTRL_RUN_A  = 4;
    localparam int CTRL_FLAG_A = 5;
    localparam int CTRL_STRIDE = 2;
    localparam int MODE_LSB    = 0;
    localparam int MODE_CNT    = 2;
    localparam int MODE_GATE   = 3;
    localparam int MODE_STRIDE = 4;
    localparam int CLK_PS_LSB  = 0;
    localparam int CLK_SEL_A   = 3;
    localparam int IEN_A       = 1;
    localparam int IEN_STRIDE  = 2;
    // ------------------------------------------------------------
    // Modes and prescale codes
    // ------------------------------------------------------------
    localparam logic [1:0] MD_13    = 2'h0;
    localparam logic [1:0] MD_16    = 2'h1;
    localparam logic [1:0] MD_8RL   = 2'h2;
    localparam logic [1:0] MD_SPLIT = 2'h3;
    localparam logic [1:0] PS_SYS12 = 2'h0;
    localparam logic [1:0] PS_SYS4  = 2'h1;
    localparam logic [1:0] PS_SYS48 = 2'h2;
    localparam logic [1:0] PS_OSC8  = 2'h3;
    // Divisor per prescale code, index = code
    localparam logic [3:0][5:0] PS_DIV = {6'h08, 6'h30, 6'h04, 6'h0C};
    localparam int PS_N      = 4;
    localparam int PIN_EV_A  = 0;
    localparam int PIN_EV_B  = 1;
    localparam int PIN_OSC   = 2;
    localparam int N_PINS    = 3;
endpackage

// File: dtc_tick_if.sv
`timescale 1ns/10ps
interface dtc_tick_if #(parameter int N = 3);
    logic [N-1:0] fall;
    logic         presc_tick;
    modport sampler (output fall);
    modport presc   (input fall, output presc_tick);
    modport core    (input fall, input presc_tick);
endinterface // dtc_tick_if

// File: dtc_edge_sampler.sv
`timescale 1ns/10ps
module dtc_edge_sampler #(
    parameter int N = 3
) (
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   ce,
    input  wire logic [N-1:0] pins,
    dtc_tick_if.sampler tk
);
    import dtc_pkg::*;
    logic [N-1:0] sync1_q;
    logic [N-1:0] sync2_q;
    logic [N-1:0] prev_q;

    // ------------------------------------------------------------
    // Two-flop synchroniser, then falling edge detect
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end else if (ce) begin
            sync1_q <= pins; // R20
            sync2_q <= sync1_q; // R20 R8
            prev_q  <= sync2_q;
        end
    end

    genvar k;
    for (k = 0; k < N; k++) begin : g_fall
        assign tk.fall[k] = prev_q[k] & ~sync2_q[k]; // R7
        a_fall_single : assert property (@(posedge clk) disable iff (rst) // R20
            ce && tk.fall[k] |=> !tk.fall[k])
            else $error("edge pulse lasted two cycles");
    end
endmodule // dtc_edge_sampler

// File: dtc_prescaler.sv
`timescale 1ns/10ps
module dtc_prescaler (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic [1:0] prescale_select,
    dtc_tick_if.presc       tk
);
    import dtc_pkg::*;
    logic [PS_N-1:0][5:0] cnt_q;
    logic [PS_N-1:0]      src;
    logic [PS_N-1:0]      div_tick;

    // ------------------------------------------------------------
    // One divider per prescale code; oscillator one counts edges
    // ------------------------------------------------------------
    genvar k;
    for (k = 0; k < PS_N; k++) begin : g_div
        assign src[k] = (k == int'(PS_OSC8)) ? tk.fall[PIN_OSC] : 1'b1;
        assign div_tick[k] = src[k] & (cnt_q[k] == PS_DIV[k] - 6'h01); // R6
        always_ff @(posedge clk) begin
            if (rst) begin
                cnt_q[k] <= '0;
            end else if (ce && src[k]) begin
                cnt_q[k] <= div_tick[k] ? 6'h00 : cnt_q[k] + 6'h01;
            end
        end
        a_div_bound : assert property (@(posedge clk) disable iff (rst) // R6
            cnt_q[k] < PS_DIV[k])
            else $error("prescale counter past divisor");
    end

    assign tk.presc_tick = div_tick[prescale_select]; // R4

    c_osc_tick : cover property (@(posedge clk) disable iff (rst)
        prescale_select == PS_OSC8 && tk.presc_tick);
endmodule // dtc_prescaler

// File: dtc_top.sv
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/10ps
module dtc_top (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire dtc_pkg::dtc_addr_t addr,
    input  wire dtc_pkg::dtc_byte_t wr_data,
    input  wire logic             wr_en,
    input  wire logic             rd_en,
    output dtc_pkg::dtc_byte_t    rd_data_q,
    input  wire logic             timer_a_event_pin,
    input  wire logic             timer_b_event_pin,
    input  wire logic             external_osc_clock,
    input  wire logic             ext_irq_a_input,
    input  wire logic             ext_irq_b_input,
    output logic                  timer_a_irq_q,
    output logic                  timer_b_irq_q,
    output logic                  timer_b_ovf_q
);
    import dtc_pkg::*;

    dtc_tick_if #(.N(N_PINS)) tk ();

    dtc_edge_sampler #(.N(N_PINS)) u_sampler (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .pins ({external_osc_clock, timer_b_event_pin, timer_a_event_pin}),
        .tk   (tk.sampler)
    );

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    dtc_byte_t       timer_mode_reg_q;
    dtc_byte_t       clock_control_reg_q;
    logic [1:0]      run_q;
    logic [1:0]      flag_q;
    logic [1:0]      ien_q;
    logic [1:0][7:0] lo_q;
    logic [1:0][7:0] hi_q;

    dtc_prescaler u_presc (
        .clk             (clk),
        .rst             (rst),
        .ce              (ce),
        .prescale_select (clock_control_reg_q[CLK_PS_LSB +: 2]),
        .tk              (tk.presc)
    );

    logic            wr_ctrl;
    logic            wr_mode;
    logic            wr_clk;
    logic            wr_ien;
    logic [1:0]      wr_lo;
    logic [1:0]      wr_hi;
    logic [1:0]      md_13;
    logic [1:0]      md_16;
    logic [1:0]      md_8rl;
    logic [1:0]      md_split;
    logic [1:0]      irq_in;
    logic [1:0]      tick_time;
    logic [1:0]      tick_ev;
    logic [1:0]      run;
    logic [1:0]      en_cnt;
    logic [1:0]      ovf_cnt;
    logic [1:0]      flag_set;
    logic [1:0][7:0] cnt_lo;
    logic [1:0][7:0] cnt_hi;
    logic [1:0][7:0] lo_d;
    logic [1:0][7:0] hi_d;
    logic [1:0]      flag_d;
    logic            a_split;
    logic            en_split_hi;
    logic            ovf_split_hi;
    dtc_byte_t       ctrl_rd;
    dtc_byte_t       ien_rd;
    dtc_byte_t       rd_mux;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign wr_ctrl  = wr_en && addr == OFF_CTRL;
    assign wr_mode  = wr_en && addr == OFF_MODE;
    assign wr_clk   = wr_en && addr == OFF_CLK;
    assign wr_ien   = wr_en && addr == OFF_IEN;
    assign irq_in   = {ext_irq_b_input, ext_irq_a_input};
    assign a_split  = md_split[0];

    // ------------------------------------------------------------
    // Per-timer timebase, gating and next count
    // ------------------------------------------------------------
    genvar i;
    for (i = 0; i < 2; i++) begin : g_tmr
        logic [1:0]  md;
        logic [12:0] c13_n;
        logic [15:0] c16_n;
        logic [7:0]  lo8_n;
        logic        all13;
        logic        all16;
        logic        all8;

        assign md          = timer_mode_reg_q[i*MODE_STRIDE + MODE_LSB +: 2]; // R3
        assign md_13[i]    = md == MD_13;
        assign md_16[i]    = md == MD_16;
        assign md_8rl[i]   = md == MD_8RL;
        assign md_split[i] = md == MD_SPLIT;
        assign wr_lo[i]    = wr_en && addr == OFF_LO_A + dtc_addr_t'(i); // R1
        assign wr_hi[i]    = wr_en && addr == OFF_HI_A + dtc_addr_t'(i); // R1
        // Select bit high: every system clock; low: prescaled tick
        assign tick_time[i] = clock_control_reg_q[CLK_SEL_A + i] | tk.presc_tick; // R5 R17
        assign tick_ev[i]   = timer_mode_reg_q[i*MODE_STRIDE + MODE_CNT] ?
                              tk.fall[i] : tick_time[i]; // R16 R7
        assign run[i] = run_q[i] &
                        (~timer_mode_reg_q[i*MODE_STRIDE + MODE_GATE] | irq_in[i]); // R18

        assign c13_n = {hi_q[i], lo_q[i][4:0]} + 13'h0001; // R12
        assign c16_n = {hi_q[i], lo_q[i]} + 16'h0001;
        assign lo8_n = lo_q[i] + 8'h01;
        assign all13 = &{hi_q[i], lo_q[i][4:0]};
        assign all16 = &{hi_q[i], lo_q[i]};
        assign all8  = &lo_q[i];

        // Bits 7..5 of the low byte are left as written in 13-bit mode
        assign cnt_lo[i] = md_13[i]  ? {lo_q[i][7:5], c13_n[4:0]} : // R12
                           md_16[i]  ? c16_n[7:0] :
                           (md_8rl[i] && all8) ? hi_q[i] : lo8_n; // R2
        assign cnt_hi[i] = md_13[i] ? c13_n[12:5] :
                           md_16[i] ? c16_n[15:8] : hi_q[i];
        assign ovf_cnt[i] = en_cnt[i] & (md_13[i] ? all13 : md_16[i] ? all16 : all8); // R14

        // Software writes take priority over counting in the same cycle
        assign lo_d[i] = wr_lo[i] ? wr_data : en_cnt[i] ? cnt_lo[i] : lo_q[i];
        assign hi_d[i] = wr_hi[i] ? wr_data :
                         (i == 0 && en_split_hi) ? hi_q[i] + 8'h01 :
                         en_cnt[i] ? cnt_hi[i] : hi_q[i];
        // Hardware set wins over a software clear
        assign flag_d[i] = flag_set[i] |
                           (wr_ctrl ? wr_data[CTRL_FLAG_A + i*CTRL_STRIDE] : flag_q[i]);
    end

    // Timer A low half always obeys its own controls
    assign en_cnt[0] = run[0] & tick_ev[0]; // R18
    // Timer B: inactive in split mode, timebase only while A is split
    assign en_cnt[1] = ~md_split[1] &
                       (a_split ? tick_time[1] : run[1] & tick_ev[1]); // R15 R2
    assign en_split_hi  = a_split & run_q[1] & tick_time[0]; // R2
    assign ovf_split_hi = en_split_hi & (&hi_q[0]);
    assign flag_set[0]  = ovf_cnt[0]; // R14
    assign flag_set[1]  = a_split ? ovf_split_hi : ovf_cnt[1]; // R15

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    assign ctrl_rd = {flag_q[1], run_q[1], flag_q[0], run_q[0], 4'h0}; // R10
    assign ien_rd  = {4'h0, ien_q[1], 1'b0, ien_q[0], 1'b0};
    assign rd_mux  = (addr == OFF_CTRL) ? ctrl_rd :
                     (addr == OFF_MODE) ? timer_mode_reg_q :
                     (addr == OFF_CLK)  ? clock_control_reg_q :
                     (addr == OFF_IEN)  ? ien_rd :
                     (addr == OFF_LO_A) ? lo_q[0] :
                     (addr == OFF_LO_B) ? lo_q[1] :
                     (addr == OFF_HI_A) ? hi_q[0] :
                     (addr == OFF_HI_B) ? hi_q[1] : RST_BYTE;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_mode_reg_q    <= RST_BYTE;
            clock_control_reg_q <= RST_BYTE;
            run_q               <= '0;
            ien_q               <= '0;
        end else if (ce) begin
            if (wr_mode) timer_mode_reg_q <= wr_data;
            if (wr_clk) clock_control_reg_q <= wr_data;
            if (wr_ctrl) run_q <= {wr_data[CTRL_RUN_A + CTRL_STRIDE], wr_data[CTRL_RUN_A]};
            if (wr_ien) ien_q <= {wr_data[IEN_A + IEN_STRIDE], wr_data[IEN_A]};
        end
    end

    // Count bytes are untouched by run changes
    always_ff @(posedge clk) begin
        if (rst) begin
            lo_q   <= '0;
            hi_q   <= '0;
            flag_q <= '0;
        end else if (ce) begin
            lo_q   <= lo_d; // R19
            hi_q   <= hi_d;
            flag_q <= flag_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data_q     <= RST_BYTE;
            timer_a_irq_q <= 1'b0;
            timer_b_irq_q <= 1'b0;
            timer_b_ovf_q <= 1'b0;
        end else if (ce) begin
            rd_data_q     <= rd_en ? rd_mux : RST_BYTE;
            timer_a_irq_q <= flag_q[0] & ien_q[0]; // R11
            timer_b_irq_q <= flag_q[1] & ien_q[1]; // R11
            timer_b_ovf_q <= ovf_cnt[1]; // R21
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_wrap_sets_flag : assert property ( // R14
        ce && en_cnt[0] && md_13[0] && (&{hi_q[0], lo_q[0][4:0]}) |=>
        flag_q[0] && hi_q[0] == 8'h00 && lo_q[0][4:0] == 5'h00)
        else $error("13-bit wrap did not set flag and clear count");
    a_irq_gate_en : assert property ( // R11
        ce && !ien_q[1] |=> !timer_b_irq_q)
        else $error("timer B request passed while disabled");
    a_stop_holds : assert property ( // R18
        ce && !run_q[0] && !wr_lo[0] && !wr_hi[0] && !a_split |=>
        $stable(lo_q[0]) && $stable(hi_q[0]))
        else $error("timer A counted while stopped");
    a_run_no_clear : assert property ( // R19
        ce && wr_ctrl && wr_data[CTRL_RUN_A] && !run_q[0] |=> $stable(lo_q[0]))
        else $error("setting run altered the count");
    a_low_carry : assert property ( // R12
        ce && en_cnt[1] && md_13[1] && lo_q[1][4:0] == 5'h1F && !wr_hi[1] && !wr_lo[1] |=>
        hi_q[1] == $past(hi_q[1]) + 8'h01 && lo_q[1][7:5] == $past(lo_q[1][7:5]))
        else $error("13-bit carry into high byte wrong");
    a_reload_value : assert property ( // R2
        ce && en_cnt[1] && md_8rl[1] && (&lo_q[1]) && !wr_lo[1] && !wr_hi[1] && !a_split |=>
        lo_q[1] == hi_q[1] && flag_q[1])
        else $error("8-bit reload missed");
    a_event_count : assert property ( // R7
        ce && md_16[0] && run[0] && timer_mode_reg_q[MODE_CNT] && tk.fall[PIN_EV_A] &&
        !wr_lo[0] && !wr_hi[0] |=> {hi_q[0], lo_q[0]} == $past({hi_q[0], lo_q[0]}) + 16'h0001)
        else $error("pin edge not counted");
    a_system_clock_select : assert property ( // R5
        ce && run[1] && md_16[1] && clock_control_reg_q[CLK_SEL_A + 1] &&
        !timer_mode_reg_q[MODE_STRIDE + MODE_CNT] && !a_split && !wr_lo[1] && !wr_hi[1]
        |=> {hi_q[1], lo_q[1]} != $past({hi_q[1], lo_q[1]}))
        else $error("system clock selection did not count");
    a_ovf_strobe : assert property ( // R21
        timer_b_ovf_q |-> $past(ovf_cnt[1]) && $past(ce))
        else $error("overflow strobe without overflow");

    c_wrap_a   : cover property (ce && flag_set[0] && md_13[0]);
    c_reload_b : cover property (ce && ovf_cnt[1] && md_8rl[1]);
    c_split_hi : cover property (ce && ovf_split_hi);
    c_irq_a    : cover property (timer_a_irq_q);
endmodule // dtc_top

// File: dtc_evt_src.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Far side: two event pins and a free-running oscillator
// ------------------------------------------------------------
module dtc_evt_src (
    input  wire logic clk,
    output logic      pin_a,
    output logic      pin_b,
    output logic      osc
);
    logic ph_q;

    initial begin
        pin_a = 1'b1;
        pin_b = 1'b1;
        osc   = 1'b1;
        ph_q  = 1'b0;
    end

    // Each oscillator level stands two cycles: a quarter of the clock rate
    always @(posedge clk) begin
        ph_q <= ~ph_q;
        if (ph_q) begin
            osc <= ~osc;
        end
    end

    // Falling edges on one pin, every level held for half cycles
    task automatic burst(input bit sel_b, input int n, input int half);
        for (int i = 0; i < n; i++) begin
            pin_a <= sel_b ? pin_a : 1'b0;
            pin_b <= sel_b ? 1'b0 : pin_b;
            repeat (half) @(posedge clk);
            pin_a <= 1'b1;
            pin_b <= 1'b1;
            repeat (half) @(posedge clk);
        end
    endtask
endmodule // dtc_evt_src

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import dtc_pkg::*;
    logic      clk;
    logic      rst;
    logic      wr_en;
    logic      rd_en;
    logic      ext_a;
    logic      pin_a;
    logic      pin_b;
    logic      osc;
    logic      timer_a_irq_q;
    logic      timer_b_irq_q;
    logic      timer_b_ovf_q;
    dtc_addr_t addr;
    dtc_byte_t wr_data;
    dtc_byte_t rd_data_q;
    int        miscompares = 0;
    int        checked     = 0;
    int        ovf_cnt     = 0;

    dtc_top uut (
        .clk(clk), .rst(rst), .ce(1'b1), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q),
        .timer_a_event_pin(pin_a), .timer_b_event_pin(pin_b),
        .external_osc_clock(osc), .ext_irq_a_input(ext_a), .ext_irq_b_input(1'b0),
        .timer_a_irq_q(timer_a_irq_q), .timer_b_irq_q(timer_b_irq_q),
        .timer_b_ovf_q(timer_b_ovf_q)
    );
    dtc_evt_src evt (.clk(clk), .pin_a(pin_a), .pin_b(pin_b), .osc(osc));

    initial clk = 1'b0;
    always #20 clk = ~clk;
    always @(posedge clk) if (timer_b_ovf_q === 1'b1) ovf_cnt <= ovf_cnt + 1;

    // ------------------------------------------------------------
    // Bus and check helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input dtc_addr_t a, input dtc_byte_t d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rdchk(input dtc_addr_t a, input dtc_byte_t exp, input dtc_byte_t msk = 8'hFF);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(rd_data_q & msk, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Run bits stay set for exactly n system clock edges
    task automatic run_for(input dtc_byte_t run, input int n);
        wr(OFF_CTRL, run);
        idle(n - 2);
        wr(OFF_CTRL, 8'h00);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        for (int i = 0; i < 8; i++) rdchk(dtc_addr_t'(i), 8'h00);
        wr(4'h9, 8'hFF);
        rdchk(4'h9, 8'h00);
        #1 chk(rd_data_q, 8'h00);
        wr(OFF_IEN, 8'hFF);
        rdchk(OFF_IEN, 8'h0A);
        wr(OFF_CLK, 8'h1B);
        rdchk(OFF_CLK, 8'h1B);
        wr(OFF_MODE, 8'hA5);
        rdchk(OFF_MODE, 8'hA5);
        for (int i = 4; i < 8; i++) wr(dtc_addr_t'(i), 8'(8'h30 + i));
        for (int i = 4; i < 8; i++) rdchk(dtc_addr_t'(i), 8'(8'h30 + i));
        wr(OFF_IEN, 8'h00);
        wr(OFF_MODE, 8'h00);
    endtask
    task automatic t_count13;
        wr(OFF_CLK, 8'h08);
        wr(OFF_LO_A, 8'h1E);
        wr(OFF_HI_A, 8'h12);
        run_for(8'h10, 3);
        rdchk(OFF_LO_A, 8'h01, 8'h1F);
        rdchk(OFF_HI_A, 8'h13);
        rdchk(OFF_CTRL, 8'h00);
    endtask
    task automatic t_ovf(input bit b);
        dtc_byte_t run;
        dtc_byte_t flag;
        int        n0;
        run  = b ? 8'h40 : 8'h10;
        flag = b ? 8'h80 : 8'h20;
        wr(OFF_CLK, 8'h18);
        wr(b ? OFF_LO_B : OFF_LO_A, 8'h1E);
        wr(b ? OFF_HI_B : OFF_HI_A, 8'hFF);
        n0 = ovf_cnt;
        wr(OFF_CTRL, run);
        idle(4);
        rdchk(OFF_CTRL, run | flag);
        chk(8'(b ? timer_b_irq_q : timer_a_irq_q), 8'h00);
        wr(OFF_IEN, b ? 8'h08 : 8'h02);
        idle(2);
        chk(8'(b ? timer_b_irq_q : timer_a_irq_q), 8'h01);
        wr(OFF_CTRL, run);
        idle(2);
        chk(8'(b ? timer_b_irq_q : timer_a_irq_q), 8'h00);
        chk(8'(ovf_cnt - n0), b ? 8'h01 : 8'h00);
        wr(OFF_CTRL, 8'h00);
        wr(OFF_IEN, 8'h00);
    endtask
    task automatic t_modes;
        wr(OFF_MODE, 8'h01);
        wr(OFF_LO_A, 8'hFF);
        wr(OFF_HI_A, 8'h00);
        run_for(8'h10, 2);
        rdchk(OFF_LO_A, 8'h01);
        rdchk(OFF_HI_A, 8'h01);
        wr(OFF_MODE, 8'h02);
        wr(OFF_LO_A, 8'hFF);
        wr(OFF_HI_A, 8'hA0);
        run_for(8'h10, 2);
        rdchk(OFF_LO_A, 8'hA1);
        rdchk(OFF_HI_A, 8'hA0);
        wr(OFF_MODE, 8'h00);
    endtask
    task automatic t_presc;
        int div[4] = '{12, 4, 48, 32};
        for (int c = 0; c < 4; c++) begin
            wr(OFF_CLK, 8'(c));
            wr(OFF_LO_A, 8'h00);
            wr(OFF_HI_A, 8'h00);
            run_for(8'h10, div[c] * 10);
            rdchk(OFF_LO_A, 8'h0A);
        end
        wr(OFF_CLK, 8'h10);
        wr(OFF_LO_B, 8'h00);
        run_for(8'h40, 8);
        rdchk(OFF_LO_B, 8'h08, 8'h1F);
    endtask
    task automatic t_gate;
        wr(OFF_CLK, 8'h08);
        wr(OFF_MODE, 8'h08);
        wr(OFF_LO_A, 8'h00);
        run_for(8'h10, 6);
        rdchk(OFF_LO_A, 8'h00);
        ext_a <= 1'b1;
        idle(3);
        run_for(8'h10, 6);
        rdchk(OFF_LO_A, 8'h06);
        ext_a <= 1'b0;
        wr(OFF_MODE, 8'h00);
    endtask
    task automatic t_counter;
        wr(OFF_MODE, 8'h44);
        wr(OFF_CLK, 8'h00);
        wr(OFF_LO_A, 8'h03);
        wr(OFF_LO_B, 8'h00);
        wr(OFF_CTRL, 8'h50);
        evt.burst(1'b0, 5, 2);
        evt.burst(1'b1, 4, 3);
        idle(6);
        wr(OFF_CTRL, 8'h00);
        rdchk(OFF_LO_A, 8'h08, 8'h1F);
        rdchk(OFF_LO_B, 8'h04, 8'h1F);
        wr(OFF_MODE, 8'h00);
    endtask
    // Split mode: high half of A counts with run B and raises flag B
    task automatic t_split;
        wr(OFF_MODE, 8'h03);
        wr(OFF_CLK, 8'h18);
        wr(OFF_LO_A, 8'h00);
        wr(OFF_HI_A, 8'hFE);
        wr(OFF_CTRL, 8'h50);
        idle(2);
        rdchk(OFF_CTRL, 8'hD0);
        wr(OFF_CTRL, 8'h00);
        rdchk(OFF_CTRL, 8'h00);
        wr(OFF_MODE, 8'h00);
    endtask

    // ------------------------------------------------------------
    // Sequence, verdict and watchdog
    // ------------------------------------------------------------
    task automatic test_done;
        $display("Checks %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        rst     = 1'b1;
        wr_en   = 1'b0;
        rd_en   = 1'b0;
        addr    = 4'h0;
        wr_data = 8'h00;
        ext_a   = 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_count13;
        t_ovf(1'b0);
        t_ovf(1'b1);
        t_modes;
        t_presc;
        t_gate;
        t_counter;
        t_split;
        test_done;
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("Error at %0t: run took too long", $time);
        test_done;
    end
endmodule // tb_top
